// File: verilog/freq_vin_start_cfg.sv
// switching-frequency and input start-threshold command registers with fault masking
`timescale 1ns/100ps
// Overview of operation
// R1 - frequency word at code 33h, written and read as linear eleven-bit kHz
// R2 - frequency applies at once when stopped; while converting waits for reload or supply lockout
// R3 - after reset frequency exponent and mantissa are generated from the stored frequency
// R4 - requests below 600 kHz map to 225, 275, 325, 375, 450 or 550
// R5 - requests above map to 650, 750, 900, 1100, 1300 or 1500 kHz
// R6 - host should keep frequency at or below 1100 kHz when stacked
// R7 - start threshold word at code 35h in volts, applied immediately even while converting
// R8 - threshold exponent resets to -2, mantissa loads from stored value
// R9 - out-of-range threshold write is refused, flagged and signalled to host
// R10 - any in-range threshold word is stored and read back unchanged
// R11 - applied or restored threshold rounds down to next supported quarter-volt step
// R12 - threshold hardware covers 2.50 V to 15.75 V in 0.25 V steps
// R13 - undervoltage fault masked until input first exceeds start threshold after power-on
// R14 - only power-on reset re-arms the mask; enable and restore do not
// R15 - linear words decode as signed mantissa times two to the signed exponent
module freq_vin_start_cfg (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // command port
    input wire logic cmd_write,
    input wire logic cmd_read,
    input wire logic cmd_send,
    input wire logic [7:0] cmd_code,
    input wire logic [15:0] cmd_wdata,
    output logic rsp_valid_q,
    output logic rsp_nack_q,
    output logic [15:0] rsp_rdata_q,
    // status
    input wire logic status_clear,
    output logic invalid_data_q,
    output logic host_alert_q,
    // stored settings
    input wire logic [10:0] nvm_freq_khz,
    input wire logic [10:0] nvm_start_man,
    // converter side
    input wire logic conversion_en,
    input wire logic analog_supply_uvlo,
    input wire logic input_above_start,
    input wire logic input_undervoltage_raw,
    output logic [10:0] applied_freq_khz_q,
    output logic [5:0] start_thresh_step_q,
    output logic input_undervoltage_fault_q
);

    // ---------------------------------------------------------------
    // helpers
    // ---------------------------------------------------------------

    // signed mantissa times two to the signed exponent plus extra scale, floored
    function automatic logic signed [31:0] lin_decode(input logic [15:0] word, input int scale_log2);
        logic signed [31:0] man;
        int sh;
        man = 32'(signed'(word[freq_vin_pkg::MAN_MSB:0]));
        sh = int'(signed'(word[freq_vin_pkg::EXP_MSB:freq_vin_pkg::EXP_LSB])) + scale_log2;
        if (sh >= 0) begin
            lin_decode = man <<< sh; // R15
        end else begin
            lin_decode = man >>> (-sh); // R15 R11
        end
    endfunction : lin_decode

    // build a frequency word that keeps the mantissa positive in eleven bits
    function automatic logic [15:0] freq_word(input logic [10:0] khz);
        if (khz > freq_vin_pkg::FREQ_MAN_MAX) begin
            freq_word = {freq_vin_pkg::FREQ_EXP_ONE, 1'b0, khz[10:1]};
        end else begin
            freq_word = {freq_vin_pkg::FREQ_EXP_ZERO, khz};
        end
    endfunction : freq_word

    // ---------------------------------------------------------------
    // synchronised pins
    // ---------------------------------------------------------------
    logic uvlo_s;
    logic above_s;
    logic uv_raw_s;

    // analog comparators and the supply lockout arrive without a clock
    level_sync #(
        .WIDTH(3)
    ) u_pin_sync (
        .clk(clk),
        .rst(rst),
        .async_in({analog_supply_uvlo, input_above_start, input_undervoltage_raw}),
        .sync_out({uvlo_s, above_s, uv_raw_s})
    );

    // ---------------------------------------------------------------
    // state
    // ---------------------------------------------------------------
    freq_vin_pkg::seq_state_t seq_q;
    freq_vin_pkg::seq_state_t seq_d;
    logic [15:0] freq_q;
    logic [15:0] freq_d;
    logic [15:0] thresh_q;
    logic [15:0] thresh_d;
    logic [10:0] applied_freq_khz_d;
    logic [5:0] start_thresh_step_d;
    logic rsp_valid_d;
    logic rsp_nack_d;
    logic [15:0] rsp_rdata_d;
    logic invalid_data_d;
    logic host_alert_d;
    logic mask_armed_q;
    logic mask_armed_d;
    logic input_undervoltage_fault_d;

    // ---------------------------------------------------------------
    // decode
    // ---------------------------------------------------------------
    logic load_now;
    logic wr_freq;
    logic wr_thresh;
    logic wr_ok;
    logic rd_ok;
    logic send_restore;
    logic signed [31:0] wr_steps;
    logic thresh_in_range;
    logic signed [31:0] freq_req_khz;
    logic signed [31:0] thresh_steps;
    logic [10:0] freq_band_khz;

    // commands are ignored during the single load cycle after reset; a read outranks a write, a write a send
    always_comb begin
        send_restore = (seq_q == freq_vin_pkg::SEQ_RUN) && cmd_send && !cmd_read && !cmd_write
            && (cmd_code == freq_vin_pkg::CMD_RESTORE_ALL);
        load_now = (seq_q == freq_vin_pkg::SEQ_LOAD) || send_restore;
        wr_freq = (seq_q == freq_vin_pkg::SEQ_RUN) && cmd_write && !cmd_read
            && (cmd_code == freq_vin_pkg::CMD_FREQ_SWITCH);
        wr_thresh = (seq_q == freq_vin_pkg::SEQ_RUN) && cmd_write && !cmd_read
            && (cmd_code == freq_vin_pkg::CMD_START_THRESH);
        wr_ok = wr_freq || wr_thresh;
        rd_ok = (cmd_code == freq_vin_pkg::CMD_FREQ_SWITCH) || (cmd_code == freq_vin_pkg::CMD_START_THRESH);
        wr_steps = lin_decode(cmd_wdata, freq_vin_pkg::STEP_LOG2);
        thresh_in_range = (wr_steps >= freq_vin_pkg::THRESH_MIN_STEPS)
            && (wr_steps <= freq_vin_pkg::THRESH_MAX_STEPS); // R9 R12
    end

    // ---------------------------------------------------------------
    // load sequencer
    // ---------------------------------------------------------------

    // one load cycle after reset release, then run
    always_comb begin
        case (seq_q)
            freq_vin_pkg::SEQ_LOAD: begin
                seq_d = freq_vin_pkg::SEQ_RUN;
            end
            freq_vin_pkg::SEQ_RUN: begin
                seq_d = freq_vin_pkg::SEQ_RUN;
            end
            default: begin
                seq_d = freq_vin_pkg::SEQ_LOAD;
            end
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            seq_q <= freq_vin_pkg::SEQ_LOAD;
        end else begin
            seq_q <= seq_d;
        end
    end

    // ---------------------------------------------------------------
    // command registers
    // ---------------------------------------------------------------

    // stored words: load from stored settings, or take a host write
    always_comb begin
        freq_d = freq_q;
        thresh_d = thresh_q;
        if (load_now) begin
            freq_d = freq_word(nvm_freq_khz); // R3
            thresh_d = {freq_vin_pkg::START_EXP_RESET, nvm_start_man}; // R8 R11
        end else begin
            if (wr_freq) begin
                freq_d = cmd_wdata; // R1
            end
            if (wr_thresh && thresh_in_range) begin
                thresh_d = cmd_wdata; // R7 R10
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            freq_q <= '0;
            thresh_q <= {freq_vin_pkg::START_EXP_RESET, freq_vin_pkg::START_MAN_RESET};
        end else begin
            freq_q <= freq_d;
            thresh_q <= thresh_d;
        end
    end

    // ---------------------------------------------------------------
    // applied hardware settings
    // ---------------------------------------------------------------
    assign freq_req_khz = lin_decode(freq_d, 0); // R15

    freq_band_map u_band (
        .req_khz(freq_req_khz),
        .eff_khz(freq_band_khz)
    );

    // frequency follows the word only when stopped, in lockout or on a reload; threshold always follows
    always_comb begin
        applied_freq_khz_d = applied_freq_khz_q;
        if (!conversion_en || uvlo_s || load_now) begin
            applied_freq_khz_d = freq_band_khz; // R2
        end
        thresh_steps = lin_decode(thresh_d, freq_vin_pkg::STEP_LOG2); // R11
        if (thresh_steps < freq_vin_pkg::THRESH_MIN_STEPS) begin
            start_thresh_step_d = freq_vin_pkg::STEP_W'(freq_vin_pkg::THRESH_MIN_STEPS); // R12
        end else if (thresh_steps > freq_vin_pkg::THRESH_MAX_STEPS) begin
            start_thresh_step_d = freq_vin_pkg::STEP_W'(freq_vin_pkg::THRESH_MAX_STEPS); // R12
        end else begin
            start_thresh_step_d = thresh_steps[5:0]; // R7 R11
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            applied_freq_khz_q <= freq_vin_pkg::FREQ_BAND_EFF[0];
            start_thresh_step_q <= freq_vin_pkg::STEP_W'(freq_vin_pkg::THRESH_MIN_STEPS);
        end else begin
            applied_freq_khz_q <= applied_freq_khz_d;
            start_thresh_step_q <= start_thresh_step_d;
        end
    end

    // ---------------------------------------------------------------
    // command responses and data status
    // ---------------------------------------------------------------

    // answer each accepted request one cycle later; set of the flag wins over its clear
    always_comb begin
        rsp_valid_d = 1'b0;
        rsp_nack_d = 1'b0;
        rsp_rdata_d = rsp_rdata_q;
        invalid_data_d = invalid_data_q;
        if (status_clear) begin
            invalid_data_d = 1'b0;
        end
        if (seq_q == freq_vin_pkg::SEQ_RUN) begin
            if (cmd_read) begin
                rsp_valid_d = 1'b1;
                rsp_nack_d = !rd_ok;
                if (cmd_code == freq_vin_pkg::CMD_FREQ_SWITCH) begin
                    rsp_rdata_d = freq_q; // R1
                end else if (cmd_code == freq_vin_pkg::CMD_START_THRESH) begin
                    rsp_rdata_d = thresh_q; // R7 R10
                end else begin
                    rsp_rdata_d = '0;
                end
            end else if (cmd_write) begin
                rsp_valid_d = 1'b1;
                rsp_nack_d = !wr_ok;
            end else if (cmd_send) begin
                rsp_valid_d = 1'b1;
                rsp_nack_d = !send_restore;
            end
        end
        if (wr_thresh && !thresh_in_range) begin
            invalid_data_d = 1'b1; // R9
        end
        host_alert_d = invalid_data_d; // R9
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rsp_valid_q <= 1'b0;
            rsp_nack_q <= 1'b0;
            rsp_rdata_q <= '0;
            invalid_data_q <= 1'b0;
            host_alert_q <= 1'b0;
        end else begin
            rsp_valid_q <= rsp_valid_d;
            rsp_nack_q <= rsp_nack_d;
            rsp_rdata_q <= rsp_rdata_d;
            invalid_data_q <= invalid_data_d;
            host_alert_q <= host_alert_d;
        end
    end

    // ---------------------------------------------------------------
    // undervoltage fault masking
    // ---------------------------------------------------------------

    // mask is armed only by reset and drops on the first crossing; enable and restore leave it alone
    always_comb begin
        mask_armed_d = mask_armed_q;
        if (above_s) begin
            mask_armed_d = 1'b0; // R13 R14
        end
        input_undervoltage_fault_d = uv_raw_s && !mask_armed_q; // R13
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            mask_armed_q <= 1'b1; // R14
            input_undervoltage_fault_q <= 1'b0;
        end else begin
            mask_armed_q <= mask_armed_d;
            input_undervoltage_fault_q <= input_undervoltage_fault_d;
        end
    end

endmodule : freq_vin_start_cfg

// File: pkg/freq_vin_pkg.sv
// constants for the switching-frequency and input start-threshold command block
package freq_vin_pkg;

    // ---------------------------------------------------------------
    // command codes
    // ---------------------------------------------------------------
    localparam logic [7:0] CMD_FREQ_SWITCH = 8'h33;
    localparam logic [7:0] CMD_START_THRESH = 8'h35;
    localparam logic [7:0] CMD_RESTORE_ALL = 8'h16;

    // ---------------------------------------------------------------
    // linear eleven-bit word layout
    // ---------------------------------------------------------------
    localparam int EXP_MSB = 15;
    localparam int EXP_LSB = 11;
    localparam int MAN_MSB = 10;
    localparam int MAN_W = 11;
    localparam int EXP_W = 5;

    // ---------------------------------------------------------------
    // start threshold: quarter-volt steps, 2.50 V to 15.75 V
    // ---------------------------------------------------------------
    localparam logic [4:0] START_EXP_RESET = 5'h1e; // exponent -2
    localparam int STEP_LOG2 = 2; // four steps per volt
    localparam int THRESH_MIN_STEPS = 32'h0a; // 2.50 V
    localparam int THRESH_MAX_STEPS = 32'h3f; // 15.75 V
    localparam int STEP_W = 6;
    localparam logic [10:0] START_MAN_RESET = 11'h00a;

    // ---------------------------------------------------------------
    // switching frequency bands in kHz: request below limit runs at effective
    // ---------------------------------------------------------------
    localparam int FREQ_BANDS = 12;
    localparam int FREQ_W = 11;
    localparam logic [11:0] FREQ_BAND_LIMIT [FREQ_BANDS] = '{
        12'h0fa, 12'h12c, 12'h15e, 12'h19a, 12'h1f4, 12'h258,
        12'h2bc, 12'h334, 12'h3e8, 12'h4b0, 12'h578, 12'h672};
    localparam logic [10:0] FREQ_BAND_EFF [FREQ_BANDS] = '{
        11'h0e1, 11'h113, 11'h145, 11'h177, 11'h1c2, 11'h226,
        11'h28a, 11'h2ee, 11'h384, 11'h44c, 11'h514, 11'h5dc};
    localparam logic [10:0] FREQ_MAN_MAX = 11'h3ff; // largest positive mantissa
    localparam logic [4:0] FREQ_EXP_ZERO = 5'h00;
    localparam logic [4:0] FREQ_EXP_ONE = 5'h01;

    // ---------------------------------------------------------------
    // power-on load sequencer
    // ---------------------------------------------------------------
    typedef enum logic [0:0] {
        SEQ_LOAD = 1'b0,
        SEQ_RUN = 1'b1
    } seq_state_t;

endpackage : freq_vin_pkg

// File: verilog/level_sync.sv
// two-flop synchroniser for asynchronous level inputs
`timescale 1ns/100ps
module level_sync #(
    parameter int WIDTH = 1
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // levels
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] sync_q;

    // first stage feeds only the second stage
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= async_in;
            sync_q <= meta_q;
        end
    end

    assign sync_out = sync_q;

endmodule : level_sync

// File: verilog/freq_band_map.sv
// maps a decoded frequency request in kHz onto a supported switching frequency
`timescale 1ns/100ps
module freq_band_map (
    // request
    input wire logic signed [31:0] req_khz,
    // result
    output logic [10:0] eff_khz
);

    // walk bands from the top so the lowest matching limit wins; above all limits clamp to the top band
    always_comb begin
        eff_khz = freq_vin_pkg::FREQ_BAND_EFF[freq_vin_pkg::FREQ_BANDS-1];
        for (int i = freq_vin_pkg::FREQ_BANDS - 1; i >= 0; i--) begin
            if (req_khz < $signed({20'h0, freq_vin_pkg::FREQ_BAND_LIMIT[i]})) begin
                eff_khz = freq_vin_pkg::FREQ_BAND_EFF[i]; // R4 R5
            end
        end
    end

endmodule : freq_band_map

// File: verification/freq_vin_start_cfg_properties.sv
// concurrent checks on the command block ports
`timescale 1ns/100ps
module freq_vin_start_cfg_properties (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // command port
    input wire logic cmd_write,
    input wire logic cmd_read,
    input wire logic cmd_send,
    input wire logic [7:0] cmd_code,
    input wire logic [15:0] cmd_wdata,
    input wire logic rsp_valid_q,
    input wire logic rsp_nack_q,
    // status
    input wire logic invalid_data_q,
    input wire logic host_alert_q,
    // converter side
    input wire logic conversion_en,
    input wire logic analog_supply_uvlo,
    input wire logic input_above_start,
    input wire logic input_undervoltage_raw,
    input wire logic [10:0] applied_freq_khz_q,
    input wire logic [5:0] start_thresh_step_q,
    input wire logic input_undervoltage_fault_q
);
    logic up_q;
    logic seen_q;
    logic req;
    logic known;
    logic thr_wr;
    logic thr_ok;
    logic restore;
    // past-load flag and first crossing memory, both cleared only by reset
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            up_q <= 1'b0;
            seen_q <= 1'b0;
        end else begin
            up_q <= 1'b1;
            seen_q <= seen_q | input_above_start;
        end
    end
    // request decode
    assign req = cmd_read | cmd_write | cmd_send;
    assign known = (cmd_read | cmd_write) ? (cmd_code == 8'h33 || cmd_code == 8'h35) : (cmd_code == 8'h16);
    assign thr_wr = up_q & cmd_write & ~cmd_read & (cmd_code == 8'h35) & (cmd_wdata[15:11] == 5'h1e);
    assign thr_ok = ~cmd_wdata[10] & (cmd_wdata[9:0] >= 10'h00a) & (cmd_wdata[9:0] <= 10'h03f);
    assign restore = up_q & cmd_send & ~cmd_read & ~cmd_write & (cmd_code == 8'h16);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    sequence s_taken; up_q && req; endsequence
    sequence s_bad_thr; thr_wr && !thr_ok; endsequence
    property p_answer; s_taken |=> rsp_valid_q; endproperty
    a_answer: assert property (p_answer) else $error("request without answer");
    property p_nack; s_taken |=> rsp_nack_q == !$past(known); endproperty
    a_nack: assert property (p_nack) else $error("wrong refusal");
    property p_thr_ok; thr_wr && thr_ok |=> start_thresh_step_q == $past(cmd_wdata[5:0]); endproperty
    a_thr_ok: assert property (p_thr_ok) else $error("threshold not applied");
    property p_thr_bad; s_bad_thr |-> ##[1:2] (invalid_data_q && host_alert_q); endproperty
    a_thr_bad: assert property (p_thr_bad) else $error("bad threshold not flagged");
    property p_alert; host_alert_q == invalid_data_q; endproperty
    a_alert: assert property (p_alert) else $error("alert differs from flag");
    property p_hold;
        $past(up_q) && !$stable(applied_freq_khz_q) |-> !$past(conversion_en) || $past(restore)
            || $past(analog_supply_uvlo, 2) || $past(analog_supply_uvlo, 3) || $past(analog_supply_uvlo, 4);
    endproperty
    a_hold: assert property (p_hold) else $error("frequency moved while converting");
    property p_masked; input_undervoltage_fault_q |-> seen_q && $past(input_undervoltage_raw, 3); endproperty
    a_masked: assert property (p_masked) else $error("fault before first crossing");
    property p_unmask; $past(seen_q, 5) && $past(input_undervoltage_raw, 3) |-> input_undervoltage_fault_q; endproperty
    a_unmask: assert property (p_unmask) else $error("fault lost after crossing");
endmodule : freq_vin_start_cfg_properties

bind freq_vin_start_cfg freq_vin_start_cfg_properties freq_vin_start_cfg_properties_i (.clk, .rst, .cmd_write,
    .cmd_read, .cmd_send, .cmd_code, .cmd_wdata, .rsp_valid_q, .rsp_nack_q, .invalid_data_q, .host_alert_q,
    .conversion_en, .analog_supply_uvlo, .input_above_start, .input_undervoltage_raw, .applied_freq_khz_q,
    .start_thresh_step_q, .input_undervoltage_fault_q);

// File: verification/host_model.sv
// host that issues word reads, word writes and send-byte commands
`timescale 1ns/100ps
module host_model (
    // clock
    input wire logic clk,
    // answer
    input wire logic rsp_valid_q,
    input wire logic rsp_nack_q,
    input wire logic [15:0] rsp_rdata_q,
    // request
    output logic cmd_write,
    output logic cmd_read,
    output logic cmd_send,
    output logic [7:0] cmd_code,
    output logic [15:0] cmd_wdata
);
    // idle request lines from time zero
    initial begin
        {cmd_write, cmd_read, cmd_send} = 3'h0;
        cmd_code = 8'h00;
        cmd_wdata = 16'h5a5a;
    end
    // one-cycle request, answer taken in the cycle after the taking edge
    // single device, no stacking, so frequencies above 1100 kHz are allowed
    task automatic xfer(input logic [1:0] k, input logic [7:0] c, input logic [15:0] d,
        output logic v, output logic n, output logic [15:0] r);
        cmd_read = (k == 2'h0);
        cmd_write = (k == 2'h1);
        cmd_send = (k == 2'h2);
        cmd_code = c;
        cmd_wdata = d;
        @(posedge clk);
        #1;
        {cmd_write, cmd_read, cmd_send} = 3'h0;
        cmd_wdata = ~d; // released data shows the inverse
        v = rsp_valid_q;
        n = rsp_nack_q;
        r = rsp_rdata_q;
    endtask : xfer
endmodule : host_model

// File: verification/testbench.sv
// self-checking bench for the frequency and start-threshold block
`timescale 1ns/100ps
module testbench;
    // ------------
    // signals, model and counters
    // ------------
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic status_clear = 1'b0, conversion_en = 1'b0, analog_supply_uvlo = 1'b0;
    logic input_above_start = 1'b0, input_undervoltage_raw = 1'b0;
    logic cmd_write, cmd_read, cmd_send, rsp_valid_q, rsp_nack_q, vl, nk;
    logic invalid_data_q, host_alert_q, input_undervoltage_fault_q;
    logic [7:0] cmd_code;
    logic [15:0] cmd_wdata, rsp_rdata_q, rdv;
    logic [10:0] nvm_freq_khz = 11'h4b0, nvm_start_man = 11'h01b, applied_freq_khz_q;
    logic [5:0] start_thresh_step_q;
    integer seed = 32'hd4c432cf, err_total = 0, num_checks = 0, fw, tw, ap, inv, i, k;
    integer lim [12] = '{250, 300, 350, 410, 500, 600, 700, 820, 1000, 1200, 1400, 1650};
    integer eff [12] = '{225, 275, 325, 375, 450, 550, 650, 750, 900, 1100, 1300, 1500};
    logic [15:0] edge_w [10] = '{16'h00f9, 16'h00fa, 16'h03e8, 16'h0b39, 16'h07ff,
        16'hf009, 16'hf00a, 16'hf03f, 16'hf040, 16'he81f};
    logic [4:0] exps [6] = '{5'h00, 5'h01, 5'h1f, 5'h1d, 5'h1e, 5'h1f};
    always #20 clk = ~clk;
    // device and host
    freq_vin_start_cfg freq_vin_start_cfg_i (.clk, .rst, .cmd_write, .cmd_read, .cmd_send, .cmd_code,
        .cmd_wdata, .rsp_valid_q, .rsp_nack_q, .rsp_rdata_q, .status_clear, .invalid_data_q, .host_alert_q,
        .nvm_freq_khz, .nvm_start_man, .conversion_en, .analog_supply_uvlo, .input_above_start,
        .input_undervoltage_raw, .applied_freq_khz_q, .start_thresh_step_q, .input_undervoltage_fault_q);
    host_model host_model_i (.clk, .rsp_valid_q, .rsp_nack_q, .rsp_rdata_q, .cmd_write, .cmd_read,
        .cmd_send, .cmd_code, .cmd_wdata);
    // linear word to integer, sh adds to the exponent
    function automatic integer dec(input logic [15:0] w, input integer sh);
        integer m;
        integer e;
        m = $signed(w[10:0]);
        e = $signed(w[15:11]) + sh;
        dec = (e >= 0) ? (m <<< e) : (m >>> (-e));
    endfunction : dec
    // supported frequency for a request in kHz
    function automatic integer band(input integer f);
        band = 1500;
        for (int j = 11; j >= 0; j--)
            if (f < lim[j]) band = eff[j];
    endfunction : band
    // shared helpers
    task automatic tick;
        @(posedge clk);
        #1;
    endtask : tick
    task automatic compare(input string n, input integer e, input logic [15:0] g);
        num_checks++;
        if (g !== 16'(e)) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", n, 16'(e), g);
        end
    endtask : compare
    task automatic load_model;
        fw = (nvm_freq_khz <= 11'h3ff) ? nvm_freq_khz : (32'h800 | (nvm_freq_khz >> 1));
        tw = 32'hf000 | nvm_start_man;
        ap = band(dec(fw, 0));
    endtask : load_model
    task automatic do_reset;
        rst = 1'b1;
        repeat (5) @(posedge clk);
        compare("freq_rst", 225, applied_freq_khz_q);
        compare("step_rst", 10, start_thresh_step_q);
        #1 rst = 1'b0;
        load_model();
        inv = 0;
        tick();
    endtask : do_reset
    // one command, model update, then all results compared
    task automatic op(input logic [1:0] kd, input logic [7:0] c, input logic [15:0] d);
        logic ok;
        integer v;
        ok = (kd == 2'h2) ? (c == 8'h16) : (c == 8'h33 || c == 8'h35);
        host_model_i.xfer(kd, c, d, vl, nk, rdv);
        compare("valid", 1, vl);
        compare("nack", !ok, nk);
        if (kd == 2'h0 && ok) compare("rdata", c == 8'h33 ? fw : tw, rdv);
        v = dec(d, 2);
        if (kd == 2'h1 && c == 8'h33) fw = d;
        if (kd == 2'h1 && c == 8'h35 && v >= 10 && v <= 63) tw = d;
        else if (kd == 2'h1 && c == 8'h35) inv = 1;
        if (kd == 2'h2 && ok) load_model();
        if (!conversion_en) ap = band(dec(fw, 0));
        tick();
        v = dec(tw, 2);
        compare("freq", ap, applied_freq_khz_q);
        compare("step", v < 10 ? 10 : (v > 63 ? 63 : v), start_thresh_step_q);
        compare("invalid", inv, invalid_data_q);
        compare("alert", inv, host_alert_q);
    endtask : op
    task automatic report_and_stop;
        $display("checks %0d errors %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : report_and_stop
    // watchdog
    initial begin
        #(40 * 6000);
        err_total++;
        report_and_stop();
    end
    // main sequence
    initial begin
        do_reset();
        op(2'h0, 8'h33, 16'h0000);
        op(2'h0, 8'h35, 16'h0000);
        for (i = 0; i < 10; i++) op(2'h1, i < 5 ? 8'h33 : 8'h35, edge_w[i]);
        // a clear in the cycle of a refused write loses to the new flag
        fork
            op(2'h1, 8'h35, 16'hf040);
            begin
                status_clear = 1'b1;
                tick();
                status_clear = 1'b0;
            end
        join
        for (i = 0; i < 90; i++) begin
            k = $unsigned($random(seed)) % 6;
            conversion_en = (k == 5) | 1'($random(seed));
            if (k < 2) op(2'h1, k ? 8'h35 : 8'h33, {exps[$unsigned($random(seed)) % 3 + 3 * k],
                11'(k ? $unsigned($random(seed)) % 128 : $random(seed))});
            else if (k == 2) op(2'h0, i[0] ? 8'h33 : 8'h35, 16'h0000);
            else if (k == 3) begin
                nvm_freq_khz = 11'($random(seed));
                nvm_start_man = 11'($unsigned($random(seed)) % 80);
                op(2'h2, 8'h16, 16'h0000);
            end else if (k == 4) op(2'($unsigned($random(seed)) % 3), 8'($random(seed)), 16'($random(seed)));
            else begin
                analog_supply_uvlo = 1'b1;
                repeat (5) tick();
                analog_supply_uvlo = 1'b0;
                ap = band(dec(fw, 0));
                repeat (4) tick();
                compare("freq_uvlo", ap, applied_freq_khz_q);
                status_clear = 1'b1;
                tick();
                status_clear = 1'b0;
                inv = 0;
            end
        end
        input_undervoltage_raw = 1'b1;
        repeat (8) tick();
        compare("fault", 0, input_undervoltage_fault_q);
        input_above_start = 1'b1;
        repeat (2) tick();
        input_above_start = 1'b0;
        repeat (6) tick();
        compare("fault", 1, input_undervoltage_fault_q);
        conversion_en = ~conversion_en;
        tick();
        conversion_en = ~conversion_en;
        op(2'h2, 8'h16, 16'h0000);
        compare("fault", 1, input_undervoltage_fault_q);
        do_reset();
        repeat (8) tick();
        compare("fault", 0, input_undervoltage_fault_q);
        report_and_stop();
    end
endmodule : testbench
